// ---- inc/wts_pkg.sv ----
package wts_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int unsigned AW_REG      = 8;
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_CMD     = 8'h04;
   localparam logic [7:0]  OFS_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_LAST    = 8'h0c;
   localparam logic [7:0]  OFS_IDLE    = 8'h10;
   localparam logic [7:0]  OFS_LOAD    = 8'h14;

   // ****************************************************************
   // Control fields
   // ****************************************************************
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_POL_BIT  = 2;
   localparam int unsigned CTRL_SRC_LSB  = 3;
   localparam logic [1:0]  MODE_OFF      = 2'h0;
   localparam logic [1:0]  MODE_LEVEL    = 2'h1;
   localparam logic [1:0]  MODE_SINGLE   = 2'h2;
   localparam logic [1:0]  MODE_FREE     = 2'h3;
   localparam logic [1:0]  SRC_MANUAL    = 2'h0;
   localparam logic [1:0]  SRC_BUS       = 2'h1;
   localparam logic [1:0]  SRC_EXT       = 2'h2;
   localparam logic [1:0]  MODE_RST      = MODE_FREE;
   localparam logic        POL_RST       = 1'h1;
   localparam logic [1:0]  SRC_RST       = SRC_MANUAL;

   // ****************************************************************
   // Command, load and status fields
   // ****************************************************************
   localparam int unsigned CMD_ARM_BIT   = 0;
   localparam int unsigned CMD_HALT_BIT  = 1;
   localparam int unsigned CMD_FIRE_BIT  = 2;
   localparam int unsigned CMD_GET_BIT   = 3;
   localparam int unsigned LOAD_IDLE_BIT = 0;
   localparam int unsigned LOAD_MSEG_BIT = 1;
   localparam int unsigned ST_PLAY_BIT   = 0;
   localparam int unsigned ST_ARM_BIT    = 1;
   localparam int unsigned ST_LOAD_BIT   = 2;
   localparam int unsigned ST_MSEG_BIT   = 3;
   localparam int unsigned ST_HALT_BIT   = 4;
   localparam int unsigned ST_PTR_LSB    = 16;

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      WTS_WAIT,
      WTS_ARMED,
      WTS_ONCE,
      WTS_LOOP,
      WTS_GATE_WAIT,
      WTS_GATE_PLAY,
      WTS_HALT
   } wts_state_e;

endpackage

// ---- src/wts_ext_detect.sv ----
`timescale 1ns/10ps
module wts_ext_detect
   import wts_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ext_in,
   input  wire logic pol_pos,
   output logic      level_hit,
   output logic      edge_hit
);

   logic prev_q;

   // Active state is high for positive polarity, low otherwise.
   assign level_hit = (ext_in == pol_pos);
   assign edge_hit  = level_hit && (prev_q != pol_pos);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= ext_in;
      end
   end

endmodule // wts_ext_detect

// ---- src/wts_idle_hold.sv ----
`timescale 1ns/10ps
module wts_idle_hold
   import wts_pkg::*;
#(
   parameter int unsigned DW = 16
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          load_evt,
   input  wire logic          has_idle,
   input  wire logic [DW-1:0] stage_i,
   input  wire logic [DW-1:0] stage_q,
   output logic      [DW-1:0] idle_i,
   output logic      [DW-1:0] idle_q
);

   logic [DW-1:0] idle_i_q;
   logic [DW-1:0] idle_q_q;
   logic          take;

   // A waveform without an idle value leaves the previous one in place.
   assign take   = load_evt && has_idle; // [RQ2]
   assign idle_i = idle_i_q;
   assign idle_q = idle_q_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_i_q <= '0;
         idle_q_q <= '0;
      end else if (take) begin
         idle_i_q <= stage_i;
         idle_q_q <= stage_q;
      end
   end

endmodule // wts_idle_hold

// ---- src/wts_sequencer.sv ----
`timescale 1ns/10ps

// Operation
// [RQ1] Halt command stops playback; idle shown until next fire command (the code also leaves halt on an arm command outside off mode or a control write).
// [RQ2] Loads without idle value keep the last defined idle value.
// [RQ3] Arm stops output, rewinds pointer, waits; trigger plays from sample zero.
// [RQ4] Fire command starts an armed sequencer whatever the origin.
// [RQ5] Bus trigger acts like fire but is ignored with external origin.
// [RQ6] Polarity is a level in level mode, an edge direction otherwise.
// [RQ7] Off mode takes no triggers, plays nothing, shows idle value.
// [RQ8] Level mode needs external origin and polarity, and starts by arm.
// [RQ9] Level mode loops from sample zero while level present, else idle.
// [RQ10] External source keeps input inactive 100 us before reasserting.
// [RQ11] Level mode is refused for a multisegment waveform.
// [RQ12] Single mode plays the waveform once per trigger, then idle.
// [RQ13] Single mode ignores triggers during a running pass.
// [RQ14] With command origin each fire gives one full single pass.
// [RQ15] Free-running mode wraps from last to first sample with no gap.
// [RQ16] Free-running mode ignores triggers, origin and polarity.
// [RQ17] Free-running playback starts when a waveform is loaded.
// [RQ18] Waiting in level or single mode, or off, shows the idle value.
// [RQ19] Origin selects remote commands or the external connector.
// [RQ20] No initiate step; sequencer returns to waiting after each pass.
// [RQ21] Outside level mode a fire command alone starts playback.
// [RQ22] Reset selects free-running mode, positive polarity, manual origin.
module wts_sequencer
   import wts_pkg::*;
#(
   parameter int unsigned DW = 16,
   parameter int unsigned PW = 16
)
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [AW_REG-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   input  wire logic              ext_fire_command,
   output logic      [PW-1:0]     smp_addr,
   input  wire logic [DW-1:0]     smp_i,
   input  wire logic [DW-1:0]     smp_q,
   output logic      [DW-1:0]     out_i,
   output logic      [DW-1:0]     out_q,
   output logic                   out_playing
);

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ****************************************************************
   // Register decode
   // ****************************************************************
   wire sel_ctrl   = (reg_addr == OFS_CTRL);
   wire sel_cmd    = (reg_addr == OFS_CMD);
   wire sel_status = (reg_addr == OFS_STATUS);
   wire sel_last   = (reg_addr == OFS_LAST);
   wire sel_idle   = (reg_addr == OFS_IDLE);
   wire sel_load   = (reg_addr == OFS_LOAD);

   wire wr_ctrl = reg_wr && sel_ctrl;
   wire wr_cmd  = reg_wr && sel_cmd;
   wire wr_last = reg_wr && sel_last;
   wire wr_idle = reg_wr && sel_idle;
   wire wr_load = reg_wr && sel_load;

   logic [1:0]    mode_q;
   logic          pol_q;
   logic [1:0]    src_q;
   logic [PW-1:0] last_q;
   logic [DW-1:0] stage_i_q;
   logic [DW-1:0] stage_q_q;
   logic          loaded_q;
   logic          mseg_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_RST; // [RQ22]
         pol_q  <= POL_RST; // [RQ22]
         src_q  <= SRC_RST; // [RQ22]
      end else if (wr_ctrl) begin
         mode_q <= reg_wdata[CTRL_MODE_LSB +: 2];
         pol_q  <= reg_wdata[CTRL_POL_BIT];
         src_q  <= reg_wdata[CTRL_SRC_LSB +: 2];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q    <= '0;
         stage_i_q <= '0;
         stage_q_q <= '0;
      end else begin
         if (wr_last) begin
            last_q <= reg_wdata[PW-1:0];
         end
         if (wr_idle) begin
            stage_i_q <= reg_wdata[DW-1:0];
            stage_q_q <= reg_wdata[16 +: DW];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loaded_q <= 1'b0;
         mseg_q   <= 1'b0;
      end else if (wr_load) begin
         loaded_q <= 1'b1;
         mseg_q   <= reg_wdata[LOAD_MSEG_BIT];
      end
   end

   // ****************************************************************
   // Commands and trigger events
   // ****************************************************************
   wire cmd_arm  = wr_cmd && reg_wdata[CMD_ARM_BIT];
   wire cmd_halt = wr_cmd && reg_wdata[CMD_HALT_BIT];
   wire cmd_fire = wr_cmd && reg_wdata[CMD_FIRE_BIT];
   wire cmd_get  = wr_cmd && reg_wdata[CMD_GET_BIT];

   wire src_ext  = (src_q == SRC_EXT);
   wire remote_t = cmd_fire || (cmd_get && !src_ext); // [RQ5] [RQ19]

   logic level_hit;
   logic edge_hit;

   wts_ext_detect u_ext (
      .clk       (clk),
      .rst_n     (rst_n),
      .ext_in    (ext_fire_command),
      .pol_pos   (pol_q),
      .level_hit (level_hit),
      .edge_hit  (edge_hit)
   );

   // The connector only counts when it is the selected origin.
   wire ext_edge  = src_ext && edge_hit; // [RQ6] [RQ19]
   wire ext_level = src_ext && level_hit; // [RQ6]
   wire fire_command_any  = remote_t || ext_edge;

   // Level mode is only offered with external origin and a plain waveform.
   wire level_ok  = src_ext && !mseg_q; // [RQ8] [RQ11]

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   wts_state_e    state_q;
   wts_state_e    state_d;
   logic [PW-1:0] ptr_q;
   logic [PW-1:0] ptr_d;
   logic          mode_chg_q;

   wire at_last = (ptr_q == last_q);
   wire [PW-1:0] ptr_inc = (at_last) ? '0 : PW'(ptr_q + 1'b1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_chg_q <= 1'b0;
      end else begin
         mode_chg_q <= wr_ctrl;
      end
   end

   always_comb begin
      state_d = state_q;
      ptr_d   = ptr_q;
      case (state_q)
         WTS_WAIT: begin
            ptr_d = '0;
            if (mode_q == MODE_FREE && loaded_q) begin
               state_d = WTS_LOOP; // [RQ17]
            end else if (mode_q == MODE_SINGLE && fire_command_any) begin
               state_d = WTS_ONCE; // [RQ21] [RQ14]
            end
         end
         WTS_ARMED: begin
            ptr_d = '0;
            if (mode_q == MODE_SINGLE && fire_command_any) begin
               state_d = WTS_ONCE; // [RQ3] [RQ4]
            end
         end
         WTS_ONCE: begin
            // Triggers are not looked at here, so a pass cannot restart.
            ptr_d = ptr_inc; // [RQ13]
            if (at_last) begin
               state_d = WTS_WAIT; // [RQ12] [RQ20]
            end
         end
         WTS_LOOP: begin
            ptr_d = ptr_inc; // [RQ15] [RQ16]
         end
         WTS_GATE_WAIT: begin
            ptr_d = '0;
            if (ext_level) begin
               state_d = WTS_GATE_PLAY; // [RQ9] [RQ10]
            end
         end
         WTS_GATE_PLAY: begin
            ptr_d = ptr_inc;
            if (!ext_level) begin
               state_d = WTS_GATE_WAIT; // [RQ9]
               ptr_d   = '0;
            end
         end
         WTS_HALT: begin
            ptr_d = '0;
            if (cmd_fire) begin
               state_d = WTS_WAIT; // [RQ1]
               if (mode_q == MODE_SINGLE) begin
                  state_d = WTS_ONCE;
               end
            end
         end
         default: begin
            state_d = WTS_WAIT;
            ptr_d   = '0;
         end
      endcase
      // Commands and mode changes take priority over playback.
      if (cmd_arm) begin
         ptr_d   = '0; // [RQ3]
         state_d = WTS_ARMED;
         if (mode_q == MODE_LEVEL) begin
            state_d = level_ok ? WTS_GATE_WAIT : WTS_WAIT; // [RQ8] [RQ11]
         end else if (mode_q == MODE_FREE || mode_q == MODE_OFF) begin
            state_d = WTS_WAIT;
         end
      end
      if (cmd_halt) begin
         ptr_d   = '0;
         state_d = WTS_HALT; // [RQ1]
      end
      if (mode_q == MODE_OFF) begin
         ptr_d   = '0;
         state_d = (state_q == WTS_HALT && !cmd_fire) ? WTS_HALT : WTS_WAIT; // [RQ7]
      end
      if (mode_chg_q) begin
         ptr_d   = '0;
         state_d = WTS_WAIT;
      end
      if (mode_q == MODE_LEVEL && !level_ok &&
          (state_q == WTS_GATE_WAIT || state_q == WTS_GATE_PLAY)) begin
         ptr_d   = '0;
         state_d = WTS_WAIT; // [RQ11]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= WTS_WAIT;
         ptr_q   <= '0;
      end else begin
         state_q <= state_d;
         ptr_q   <= ptr_d;
      end
   end

   // ****************************************************************
   // Output stage
   // ****************************************************************
   logic [DW-1:0] idle_i;
   logic [DW-1:0] idle_q;

   wts_idle_hold #(
      .DW (DW)
   ) u_idle (
      .clk      (clk),
      .rst_n    (rst_n),
      .load_evt (wr_load),
      .has_idle (reg_wdata[LOAD_IDLE_BIT]),
      .stage_i  (stage_i_q),
      .stage_q  (stage_q_q),
      .idle_i   (idle_i),
      .idle_q   (idle_q)
   );

   wire playing = (state_q == WTS_ONCE) || (state_q == WTS_LOOP) ||
                  (state_q == WTS_GATE_PLAY);

   logic [DW-1:0] out_i_q;
   logic [DW-1:0] out_q_q;
   logic          out_play_q;

   // The sample memory answers combinationally, so data and address
   // share a cycle; the output register adds one cycle of delay.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_i_q    <= '0;
         out_q_q    <= '0;
         out_play_q <= 1'b0;
      end else begin
         out_i_q    <= playing ? smp_i : idle_i; // [RQ18] [RQ7] [RQ1]
         out_q_q    <= playing ? smp_q : idle_q; // [RQ18] [RQ7] [RQ1]
         out_play_q <= playing;
      end
   end

   assign smp_addr    = ptr_q;
   assign out_i       = out_i_q;
   assign out_q       = out_q_q;
   assign out_playing = out_play_q;

   // ****************************************************************
   // Read back
   // ****************************************************************
   wire armed = (state_q == WTS_ARMED) || (state_q == WTS_GATE_WAIT) ||
                (state_q == WTS_GATE_PLAY);

   logic [31:0] status_w;
   logic [31:0] rd_mux;

   always_comb begin
      status_w = '0;
      status_w[ST_PLAY_BIT] = playing;
      status_w[ST_ARM_BIT]  = armed;
      status_w[ST_LOAD_BIT] = loaded_q;
      status_w[ST_MSEG_BIT] = mseg_q;
      status_w[ST_HALT_BIT] = (state_q == WTS_HALT);
      status_w[ST_PTR_LSB +: PW] = ptr_q;
   end

   always_comb begin
      rd_mux = '0;
      if (sel_ctrl) begin
         rd_mux[CTRL_MODE_LSB +: 2] = mode_q;
         rd_mux[CTRL_POL_BIT]       = pol_q;
         rd_mux[CTRL_SRC_LSB +: 2]  = src_q;
      end else if (sel_status) begin
         rd_mux = status_w;
      end else if (sel_last) begin
         rd_mux[PW-1:0] = last_q;
      end else if (sel_idle) begin
         rd_mux[DW-1:0]  = idle_i;
         rd_mux[16 +: DW] = idle_q;
      end
   end

   logic [31:0] rdata_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;

endmodule // wts_sequencer

// ---- tb/wts_smp_mem.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Sample memory seen by the playback pointer
// ****************************************************************
// Each address answers with a pattern unique within its low byte, so a skipped or repeated sample shows.
module wts_smp_mem
   import wts_pkg::*;
#(
   parameter int unsigned DW = 16,
   parameter int unsigned PW = 16
)
(
   input  wire logic [PW-1:0] smp_addr,
   output logic      [DW-1:0] smp_i,
   output logic      [DW-1:0] smp_q
);
   assign smp_i = DW'({8'h5a, smp_addr[7:0]});
   assign smp_q = DW'({8'hc3, ~smp_addr[7:0]});
endmodule // wts_smp_mem

// ---- tb/wts_seq_asserts.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Port checker
// ****************************************************************
module wts_seq_chk
   import wts_pkg::*;
#(
   parameter int unsigned DW = 16,
   parameter int unsigned PW = 16
)
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [AW_REG-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire logic              ext_fire_command,
   input wire logic [PW-1:0]     smp_addr,
   input wire logic [DW-1:0]     smp_i,
   input wire logic [DW-1:0]     smp_q,
   input wire logic [DW-1:0]     out_i,
   input wire logic [DW-1:0]     out_q,
   input wire logic              out_playing
);
   wire cmd_wr  = reg_wr && (reg_addr == OFS_CMD);
   wire ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_RDATA_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   AST_PLAY_SAMPLE: assert property (out_playing |-> out_i == $past(smp_i) && out_q == $past(smp_q))
      else $error("played sample differs from memory");
   AST_PTR_STEP: assert property ($changed(smp_addr) |-> smp_addr == '0 || smp_addr == PW'($past(smp_addr) + 1))
      else $error("pointer jumped");
   AST_START_ZERO: assert property ($rose(out_playing) |-> $past(smp_addr) == '0)
      else $error("playback did not start at first sample");
   AST_HALT_STOP: assert property (cmd_wr && reg_wdata[CMD_HALT_BIT] |-> ##2 !out_playing [*3])
      else $error("output kept playing after halt");
   AST_ARM_STOP: assert property (cmd_wr && reg_wdata[CMD_ARM_BIT] && !reg_wdata[CMD_FIRE_BIT] |-> ##2 !out_playing)
      else $error("output kept playing after arm");
   AST_OFF_QUIET: assert property (ctrl_wr && reg_wdata[CTRL_MODE_LSB +: 2] == MODE_OFF |-> ##3 !out_playing [*8])
      else $error("samples played in off mode");
   AST_IDLE_HOLD: assert property (!out_playing && !$past(out_playing) && !$past(reg_wr) && !$past(reg_wr, 2)
      |-> $stable(out_i) && $stable(out_q))
      else $error("idle value moved");
   COV_START: cover property ($rose(out_playing));
   COV_WRAP: cover property (out_playing && smp_addr == '0 && $past(smp_addr) != '0);
   COV_STOP: cover property ($fell(out_playing));
endmodule // wts_seq_chk

bind wts_sequencer wts_seq_chk #(.DW(DW), .PW(PW)) u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_fire_command(ext_fire_command),
   .smp_addr(smp_addr), .smp_i(smp_i), .smp_q(smp_q), .out_i(out_i), .out_q(out_q), .out_playing(out_playing));

// ---- tb/test_waveform_trigger_sequencer.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Sequencer bench
// ****************************************************************
module test_waveform_trigger_sequencer
   import wts_pkg::*;
;
   localparam logic [31:0] IDLEV = 32'habcd_1234;
   logic        clk;
   logic        rstn;
   logic        reg_wr;
   logic        reg_rd;
   logic        ext_fire_command;
   logic        out_playing;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic [31:0] rv;
   logic [15:0] smp_addr;
   logic [15:0] smp_i;
   logic [15:0] smp_q;
   logic [15:0] out_i;
   logic [15:0] out_q;
   int          failures = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          p;

   wts_sequencer #(.DW(16), .PW(16)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_fire_command(ext_fire_command), .smp_addr(smp_addr),
      .smp_i(smp_i), .smp_q(smp_q), .out_i(out_i), .out_q(out_q), .out_playing(out_playing));
   wts_smp_mem #(.DW(16), .PW(16)) u_mem (.smp_addr(smp_addr), .smp_i(smp_i), .smp_q(smp_q));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // The gate pause alone takes 20000 cycles; the ceiling leaves room for the rest.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 25000) begin
         failures++;
         print_verdict();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask

   function logic [31:0] expv(input logic [7:0] k);
      return {8'hc3, ~k, 8'h5a, k};
   endfunction

   // Counts played cycles; with chk set each played sample must follow 0,1,2,3,0...
   task watch(input int n, input bit chk);
      logic [7:0] idx;
      idx = 8'h0;
      p = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (out_playing === 1'b1) begin
            p++;
            if (chk)
               check({out_q, out_i}, expv(idx));
            idx = (idx == 8'h3) ? 8'h0 : idx + 8'h1;
         end
      end
   endtask

   task t_free;
      rd(OFS_CTRL);
      check(rv, 32'h7);
      watch(4, 0);
      check(p, 0);
      wr(OFS_LAST, 32'h3);
      wr(OFS_IDLE, IDLEV);
      fork
         wr(OFS_LOAD, 32'h1);
         watch(14, 1);
      join
      check(p > 8, 1'b1);
      fork
         wr(OFS_CMD, 32'h4);
         begin
            @(posedge clk);
            ext_fire_command <= 1'b1;
            @(posedge clk);
            ext_fire_command <= 1'b0;
         end
         watch(10, 0);
      join
      check(p, 10);
      rd(OFS_IDLE);
      check(rv, IDLEV);
      wr(OFS_CMD, 32'h2);
      repeat (2) @(posedge clk);
      watch(6, 0);
      check(p, 0);
      check({out_q, out_i}, IDLEV);
      rd(OFS_STATUS);
      check(rv, 32'h14);
      fork
         wr(OFS_CMD, 32'h4);
         watch(12, 0);
      join
      check(p > 4, 1'b1);
      wr(OFS_IDLE, 32'h1111_2222);
      wr(OFS_LOAD, 32'h0);
      wr(OFS_CMD, 32'h2);
      watch(6, 0);
      check({out_q, out_i}, IDLEV);
      $display("test free running done");
   endtask

   task t_single;
      wr(OFS_CTRL, 32'h2);
      watch(6, 0);
      check(p, 0);
      check({out_q, out_i}, IDLEV);
      fork
         begin
            wr(OFS_CMD, 32'h4);
            wr(OFS_CMD, 32'h4);
         end
         watch(14, 1);
      join
      check(p, 4);
      wr(OFS_CTRL, 32'h0e);
      fork
         wr(OFS_CMD, 32'h8);
         watch(12, 1);
      join
      check(p, 4);
      wr(OFS_CTRL, 32'h16);
      fork
         wr(OFS_CMD, 32'h8);
         watch(10, 0);
      join
      check(p, 0);
      wr(OFS_CMD, 32'h1);
      fork
         wr(OFS_CMD, 32'h4);
         watch(12, 1);
      join
      check(p, 4);
      wr(OFS_CTRL, 32'h12);
      @(posedge clk);
      ext_fire_command <= 1'b1;
      fork
         begin
            repeat (3) @(posedge clk);
            ext_fire_command <= 1'b0;
         end
         watch(16, 1);
      join
      check(p, 4);
      $display("test single done");
   endtask

   task t_level;
      wr(OFS_CTRL, 32'h15);
      @(posedge clk);
      ext_fire_command <= 1'b1;
      watch(8, 0);
      check(p, 0);
      fork
         wr(OFS_CMD, 32'h1);
         watch(16, 1);
      join
      check(p > 8, 1'b1);
      @(posedge clk);
      ext_fire_command <= 1'b0;
      repeat (3) @(posedge clk);
      watch(6, 0);
      check(p, 0);
      check({out_q, out_i}, IDLEV);
      // The gate stays low for 100 us at 5 ns per cycle before it rises again.
      repeat (20000) @(posedge clk);
      ext_fire_command <= 1'b1;
      watch(8, 1);
      check(p, 7);
      @(posedge clk);
      ext_fire_command <= 1'b0;
      // Low level is active here, so only the multisegment refusal keeps the output idle.
      wr(OFS_LOAD, 32'h2);
      wr(OFS_CTRL, 32'h11);
      wr(OFS_CMD, 32'h1);
      watch(10, 0);
      check(p, 0);
      $display("test level done");
   endtask

   task t_off;
      wr(OFS_CTRL, 32'h0);
      fork
         wr(OFS_CMD, 32'h4);
         watch(10, 0);
      join
      check(p, 0);
      check({out_q, out_i}, IDLEV);
      rd(8'h3c);
      check(rv, 32'h0);
      $display("test off done");
   endtask

   initial begin
      rstn      = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h0;
      reg_wdata = 32'h0;
      ext_fire_command  = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_free();
      t_single();
      t_level();
      t_off();
      print_verdict();
   end
endmodule // test_waveform_trigger_sequencer
